// ---- logic/measurement_mode_pkg.sv ----
// package: offsets, fields, reset values and phase codes for the measurement mode block
package mode_pkg;
    localparam logic [7:0] MEASUREMENT_MODE_ADDR = 8'h0b;  // register address
    localparam logic [7:0] MEASUREMENT_MODE_RST  = 8'h70;  // zero-cross enables all set
    localparam int         PERIOD_SEL_LSB        = 0;      // bits 1:0
    localparam int         PEAK_SEL_LSB          = 2;      // bits 3:2
    localparam int         ZX_EN_LSB             = 4;      // bits 6:4
    localparam logic [7:0] MEASUREMENT_MODE_MASK = 8'h7f;  // bit 7 reserved
    localparam int         SAMPLE_W              = 24;     // width of phase samples
    localparam int         PHASE_CNT             = 3;      // phases a, b, c

    // phase codes of the two-bit selector fields
    typedef enum logic [1:0] {
        PHASE_A   = 2'h0,
        PHASE_B   = 2'h1,
        PHASE_C   = 2'h2,
        PHASE_RSV = 2'h3
    } phase_sel_t;
endpackage

// ---- logic/measurement_mode_if.sv ----
// interface: peak comparison request and result between top and comparator
`timescale 1ns/1ns
interface peak_cmp_if;
    import mode_pkg::*;
    logic [SAMPLE_W-1:0] sample;     // selected phase magnitude
    logic [SAMPLE_W-1:0] level;      // programmed peak level
    logic                valid;      // a legal phase is selected
    logic                over;       // sample above level
    modport top (output sample, output level, output valid, input over);
    modport cmp (input sample, input level, input valid, output over);
endinterface

// ---- logic/peak_compare.sv ----
// peak comparator: strict above-level test for one selected phase
`timescale 1ns/1ns
module peak_compare (
    peak_cmp_if.cmp c                // comparison group
);
    import mode_pkg::*;
    // reserved selector never raises a flag
    always_comb begin
        c.over = c.valid && (c.sample > c.level);
    end
endmodule

// ---- logic/measurement_mode_select.sv ----
// measurement mode register and the period, peak and zero-cross phase routing
`timescale 1ns/1ns
// Notes on behaviour
// - host writes register, it configures measurements
// - bits 1:0 pick period phase, reset zero
// - bits 3:2 pick peak phase, reset zero
// - selected voltage above level sets voltage flag
// - selected current above level sets current flag
// - bits 6:4 pick zero-crossing counting phases
// - only enabled phases join zero-cross uses
// - bit4 A, bit5 B, bit6 C, reset seven
module measurement_mode_select (
    input  wire logic                               clk_sys,          // system clock
    input  wire logic                               rstn,             // async reset, low
    input  wire logic                               reg_wr,           // register write strobe
    input  wire logic                               reg_rd,           // register read strobe
    input  wire logic [7:0]                         reg_addr,         // register address
    input  wire logic [7:0]                         reg_wdata,        // write data
    output logic      [7:0]                         reg_rdata,        // registered read data
    output logic                                    reg_hit,          // address decodes here
    input  wire logic [mode_pkg::PHASE_CNT-1:0][mode_pkg::SAMPLE_W-1:0] volt_mag, // per phase
    input  wire logic [mode_pkg::PHASE_CNT-1:0][mode_pkg::SAMPLE_W-1:0] curr_mag, // per phase
    input  wire logic [mode_pkg::SAMPLE_W-1:0]      voltage_peak_level, // voltage threshold
    input  wire logic [mode_pkg::SAMPLE_W-1:0]      current_peak_level, // current threshold
    input  wire logic [mode_pkg::PHASE_CNT-1:0]     zx_raw,           // raw zero-cross pulses
    input  wire logic [mode_pkg::PHASE_CNT-1:0]     zx_timeout_raw,   // raw per-phase timeouts
    input  wire logic [mode_pkg::PHASE_CNT-1:0]     dip_raw,          // raw per-phase dips
    output logic                                    voltage_peak_flag, // peak event, high while above level
    output logic                                    current_peak_flag, // peak event, high while above level
    output logic [1:0]                              period_source_sel, // period phase
    output logic [1:0]                              peak_phase_sel,   // peak phase
    output logic [mode_pkg::PHASE_CNT-1:0]          zero_cross_phase_enable, // zx enables
    output logic                                    period_zx,        // period source crossing
    output logic [mode_pkg::PHASE_CNT-1:0]          zx_count_en,      // crossings to count
    output logic                                    zx_timeout,       // enabled-phase timeout
    output logic                                    voltage_dip_detect // enabled-phase dip
);
    import mode_pkg::*;

    logic [7:0] measurement_mode;       // stored register
    logic [7:0] next_measurement_mode;  // next register value
    logic [7:0] next_reg_rdata;         // next read data
    logic       next_vpk;               // next voltage flag
    logic       next_ipk;               // next current flag
    logic       next_period_zx;         // next period crossing
    logic [PHASE_CNT-1:0] next_zx_count_en; // next counting enables
    logic       next_zx_timeout;        // next timeout
    logic       next_dip;               // next dip
    logic       v_over;                 // comparator result, voltage
    logic       i_over;                 // comparator result, current

    peak_cmp_if vif ();                 // voltage comparison group
    peak_cmp_if iif ();                 // current comparison group

    // pick one phase out of three; reserved code gives zero
    function automatic logic [SAMPLE_W-1:0] pick_phase(
        input logic [PHASE_CNT-1:0][SAMPLE_W-1:0] v,
        input logic [1:0]                         sel
    );
        logic [SAMPLE_W-1:0] r;
        r = '0;
        case (sel)
            PHASE_A: r = v[0];
            PHASE_B: r = v[1];
            PHASE_C: r = v[2];
            default: r = '0;
        endcase
        return r;
    endfunction

    // register next value and read path
    always_comb begin
        next_measurement_mode = measurement_mode;
        if (reg_wr && reg_addr == MEASUREMENT_MODE_ADDR) begin
            next_measurement_mode = reg_wdata & MEASUREMENT_MODE_MASK;
        end
        next_reg_rdata = reg_rdata;
        if (reg_rd) begin
            // unmapped addresses read zero
            next_reg_rdata = (reg_addr == MEASUREMENT_MODE_ADDR) ? measurement_mode : 8'h00;
        end
    end

    // field decode
    always_comb begin
        reg_hit                 = (reg_addr == MEASUREMENT_MODE_ADDR);
        period_source_sel       = measurement_mode[PERIOD_SEL_LSB +: 2];
        peak_phase_sel          = measurement_mode[PEAK_SEL_LSB +: 2];
        zero_cross_phase_enable = measurement_mode[ZX_EN_LSB +: PHASE_CNT];
    end

    // comparator feeds; reserved peak code disables both compares
    always_comb begin
        vif.sample = pick_phase(volt_mag, peak_phase_sel);
        vif.level  = voltage_peak_level;
        vif.valid  = (peak_phase_sel != PHASE_RSV);
        iif.sample = pick_phase(curr_mag, peak_phase_sel);
        iif.level  = current_peak_level;
        iif.valid  = (peak_phase_sel != PHASE_RSV);
        v_over     = vif.over;
        i_over     = iif.over;
    end

    peak_compare u_vcmp (
        .c (vif.cmp)
    );

    peak_compare u_icmp (
        .c (iif.cmp)
    );

    // event routing; a disabled phase cannot reach the zero-cross count, period, timeout or dip outputs (peak flags are not gated)
    always_comb begin
        next_vpk         = v_over;
        next_ipk         = i_over;
        next_zx_count_en = zx_raw & zero_cross_phase_enable;
        next_zx_timeout  = |(zx_timeout_raw & zero_cross_phase_enable);
        next_dip         = |(dip_raw & zero_cross_phase_enable);
        // period source must also be enabled to be measured
        next_period_zx   = |({PHASE_CNT{period_source_sel != PHASE_RSV}} & zx_raw
                           & zero_cross_phase_enable
                           & (3'h1 << period_source_sel));
    end

    // state registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            measurement_mode  <= MEASUREMENT_MODE_RST;
            reg_rdata         <= 8'h00;
            voltage_peak_flag <= 1'b0;
            current_peak_flag <= 1'b0;
            period_zx         <= 1'b0;
            zx_count_en       <= 3'h0;
            zx_timeout        <= 1'b0;
            voltage_dip_detect <= 1'b0;
        end else begin
            measurement_mode  <= next_measurement_mode;
            reg_rdata         <= next_reg_rdata;
            voltage_peak_flag <= next_vpk;
            current_peak_flag <= next_ipk;
            period_zx         <= next_period_zx;
            zx_count_en       <= next_zx_count_en;
            zx_timeout        <= next_zx_timeout;
            voltage_dip_detect <= next_dip;
        end
    end

    // write lands one edge later with bit 7 cleared
    a_write_store: assert property (@(posedge clk_sys) disable iff (!rstn)
        (reg_wr && reg_addr == MEASUREMENT_MODE_ADDR)
        |=> measurement_mode == ($past(reg_wdata) & MEASUREMENT_MODE_MASK))
        else $error("write not stored");
    a_bit7_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        !measurement_mode[7] && !(reg_rdata[7]))
        else $error("reserved bit set");
    a_period_field: assert property (@(posedge clk_sys) disable iff (!rstn)
        period_source_sel == measurement_mode[1:0] ##0 (reg_rd && reg_hit)
        |=> reg_rdata[1:0] == $past(period_source_sel))
        else $error("period field readback");
    a_peak_voltage: assert property (@(posedge clk_sys) disable iff (!rstn)
        (peak_phase_sel == PHASE_B && volt_mag[1] > voltage_peak_level)
        |=> voltage_peak_flag)
        else $error("voltage peak missed");
    a_peak_current: assert property (@(posedge clk_sys) disable iff (!rstn)
        (peak_phase_sel == PHASE_RSV || curr_mag[peak_phase_sel] <= current_peak_level)
        |=> !current_peak_flag)
        else $error("current peak false");
    a_peak_field: assert property (@(posedge clk_sys) disable iff (!rstn)
        peak_phase_sel == measurement_mode[3:2])
        else $error("peak field decode");
    a_zx_count: assert property (@(posedge clk_sys) disable iff (!rstn)
        ##1 zx_count_en == ($past(zx_raw) & $past(zero_cross_phase_enable)))
        else $error("zero-cross count gating");
    a_dip_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
        (dip_raw & zero_cross_phase_enable) == 3'h0 |=> !voltage_dip_detect)
        else $error("dip from disabled phase");
    a_zx_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        zero_cross_phase_enable == measurement_mode[6:4])
        else $error("zero-cross enable map");

    // bus events that start the register checks
    sequence s_mode_write;
        reg_wr && reg_hit;
    endsequence

    sequence s_mode_read;
        reg_rd && reg_hit;
    endsequence

    // selected phase above its level; one sequence per watched phase
    sequence s_volt_above_a;
        peak_phase_sel == PHASE_A && volt_mag[0] > voltage_peak_level;
    endsequence

    sequence s_volt_above_c;
        peak_phase_sel == PHASE_C && volt_mag[2] > voltage_peak_level;
    endsequence

    sequence s_curr_above_b;
        peak_phase_sel == PHASE_B && curr_mag[1] > current_peak_level;
    endsequence

    // defaults must stand at the first edge after reset lets go
    a_reset_default: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(rstn) |-> measurement_mode == MEASUREMENT_MODE_RST)
        else $error("reset default wrong");
    // each field follows the written byte, checked against the bus not the register
    a_period_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_mode_write |=> period_source_sel == 2'($past(reg_wdata) >> PERIOD_SEL_LSB))
        else $error("period field not written");
    a_peak_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_mode_write |=> peak_phase_sel == 2'($past(reg_wdata) >> PEAK_SEL_LSB))
        else $error("peak field not written");
    a_zx_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_mode_write |=> zero_cross_phase_enable == 3'($past(reg_wdata) >> ZX_EN_LSB))
        else $error("zero-cross enables not written");
    // read data one edge after the strobe, held between reads
    a_read_data: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_mode_read |=> reg_rdata == $past(measurement_mode))
        else $error("read data wrong");
    a_read_other: assert property (@(posedge clk_sys) disable iff (!rstn)
        (reg_rd && !reg_hit) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_read_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    // voltage phases a and c and current phase b of the peak compare
    a_peak_volt_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_volt_above_a |=> voltage_peak_flag)
        else $error("phase a voltage peak missed");
    a_peak_volt_c: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_volt_above_c |=> voltage_peak_flag)
        else $error("phase c voltage peak missed");
    a_peak_curr_b: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_curr_above_b |=> current_peak_flag)
        else $error("phase b current peak missed");
    // reserved peak code must keep both flags quiet
    a_peak_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
        (peak_phase_sel == PHASE_RSV) |=> (!voltage_peak_flag && !current_peak_flag))
        else $error("peak flag on reserved code");
    // timeout and dip pass from enabled phases, and only from them
    a_timeout_pass: assert property (@(posedge clk_sys) disable iff (!rstn)
        (zx_timeout_raw & zero_cross_phase_enable) != 3'h0 |=> zx_timeout)
        else $error("enabled timeout lost");
    a_timeout_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
        (zx_timeout_raw & zero_cross_phase_enable) == 3'h0 |=> !zx_timeout)
        else $error("timeout from disabled phase");
    a_dip_pass: assert property (@(posedge clk_sys) disable iff (!rstn)
        (dip_raw & zero_cross_phase_enable) != 3'h0 |=> voltage_dip_detect)
        else $error("enabled dip lost");
    // reserved period code measures no phase
    a_period_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
        (period_source_sel == PHASE_RSV) |=> !period_zx)
        else $error("period crossing on reserved code");
endmodule

// ---- testbench/test_measurement_mode_select.sv ----
// testbench: register access, phase routing and peak flags of the mode block
`timescale 1ns/1ns
// compare, count, report one line on a miss
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module test_measurement_mode_select;
    import mode_pkg::*;
    logic                               clk_sys   = 1'b0;  // 25 MHz system clock
    logic                               rstn      = 1'b0;  // held low at start
    logic                               reg_wr    = 1'b0;  // write strobe
    logic                               reg_rd    = 1'b0;  // read strobe
    logic [7:0]                         reg_addr  = 8'h00; // register address
    logic [7:0]                         reg_wdata = 8'h00; // write data
    logic [PHASE_CNT-1:0][SAMPLE_W-1:0] volt_mag  = '0;    // per-phase voltage
    logic [PHASE_CNT-1:0][SAMPLE_W-1:0] curr_mag  = '0;    // per-phase current
    logic [SAMPLE_W-1:0]                v_level   = 24'h000100; // voltage threshold
    logic [SAMPLE_W-1:0]                c_level   = 24'h000200; // current threshold
    logic [PHASE_CNT-1:0]               zx_raw    = 3'h0;  // raw crossings
    logic [PHASE_CNT-1:0]               tmo_raw   = 3'h0;  // raw timeouts
    logic [PHASE_CNT-1:0]               dip_raw   = 3'h7;  // raw dips, all phases at first
    logic [7:0]                         reg_rdata;         // read data
    logic                               reg_hit;           // address decode
    logic                               v_flag, c_flag;    // peak flags
    logic [1:0]                         per_sel, pk_sel;   // selector decodes
    logic [PHASE_CNT-1:0]               zx_en, zx_cnt;     // enables and counts
    logic                               per_zx, zx_tmo, dip; // routed events
    int                                 err_total  = 0;    // mismatches seen
    int                                 n_compared = 0;    // compares made

    measurement_mode_select u_measurement_mode_select (
        .clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .volt_mag(volt_mag), .curr_mag(curr_mag), .voltage_peak_level(v_level),
        .current_peak_level(c_level), .zx_raw(zx_raw), .zx_timeout_raw(tmo_raw),
        .dip_raw(dip_raw), .voltage_peak_flag(v_flag), .current_peak_flag(c_flag),
        .period_source_sel(per_sel), .peak_phase_sel(pk_sel),
        .zero_cross_phase_enable(zx_en), .period_zx(per_zx), .zx_count_en(zx_cnt),
        .zx_timeout(zx_tmo), .voltage_dip_detect(dip));

    // free-running clock, half period 20 ns
    always #20 clk_sys = ~clk_sys;

    // one magnitude on one phase, others quiet
    function automatic logic [PHASE_CNT-1:0][SAMPLE_W-1:0] place(int q, logic [23:0] v);
        place    = '0;
        place[q] = v;
    endfunction

    // single write cycle; returns just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        #1;
    endtask

    // single read cycle; data lands one edge after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        `CHK("reg_rdata", ex, reg_rdata)
        `CHK("reg_hit", (a == MEASUREMENT_MODE_ADDR), reg_hit)
    endtask

    // drive magnitudes, wait for the registered flags
    task automatic peak(input int q, input logic [23:0] dv, input logic ex);
        @(posedge clk_sys);
        volt_mag <= place(q, v_level + dv);
        curr_mag <= place(q, c_level + dv);
        @(posedge clk_sys);
        #1;
        `CHK("voltage_peak_flag", ex, v_flag)
        `CHK("current_peak_flag", ex, c_flag)
    endtask

    // verdict in one place for both normal end and watchdog
    task automatic tally_and_finish;
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        #1;
        `CHK("period_sel", 2'h0, per_sel)
        `CHK("peak_sel", 2'h0, pk_sel)
        `CHK("zx_enable", 3'h7, zx_en)
        rd(MEASUREMENT_MODE_ADDR, MEASUREMENT_MODE_RST);
        wr(MEASUREMENT_MODE_ADDR, 8'hff);
        rd(MEASUREMENT_MODE_ADDR, 8'h7f);
        wr(8'h0c, 8'h00);
        rd(MEASUREMENT_MODE_ADDR, 8'h7f);
        rd(8'h0c, 8'h00);
        // each peak phase against each driven phase; only a match flags
        for (int p = 0; p < 3; p++) begin
            wr(MEASUREMENT_MODE_ADDR, 8'(8'h70 | (p << 2)));
            `CHK("peak_sel", 2'(p), pk_sel)
            for (int q = 0; q < 3; q++) peak(q, 24'h1, p == q);
        end
        peak(2, 24'h0, 1'b0);
        wr(MEASUREMENT_MODE_ADDR, 8'h7c);
        peak(2, 24'h1, 1'b0);
        // every enable pattern against every period phase
        for (int e = 0; e < 8; e++) begin
            for (int p = 0; p < 3; p++) begin
                wr(MEASUREMENT_MODE_ADDR, 8'((e << 4) | p));
                @(posedge clk_sys);
                zx_raw  <= 3'(1 << p);
                tmo_raw <= 3'(1 << p);
                dip_raw <= 3'(1 << p);
                @(posedge clk_sys);
                #1;
                `CHK("zx_enable", 3'(e), zx_en)
                `CHK("period_sel", 2'(p), per_sel)
                `CHK("zx_count_en", 3'(e & (1 << p)), zx_cnt)
                `CHK("period_zx", e[p], per_zx)
                `CHK("zx_timeout", e[p], zx_tmo)
                `CHK("dip", e[p], dip)
            end
        end
        // reserved period code: crossings still counted, no period event
        wr(MEASUREMENT_MODE_ADDR, 8'h73);
        @(posedge clk_sys);
        zx_raw <= 3'h7;
        @(posedge clk_sys);
        #1;
        `CHK("period_sel", 2'h3, per_sel)
        `CHK("period_zx", 1'b0, per_zx)
        `CHK("zx_count_en", 3'h7, zx_cnt)
        tally_and_finish();
    end

    // watchdog: run needs well under 1000 cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_total++;
        tally_and_finish();
    end
endmodule
